// file: verilog/test_port_pkg.sv
// Package for the test access port block: identity word layout, TAP states, instructions.
// Assumes the includer imports the whole package.
`default_nettype none
package test_port_pkg;
   // ********************************************
   // Identity word layout
   // ********************************************
   localparam int ID_WIDTH = 32;
   localparam int REV_MSB = 31;
   localparam int REV_LSB = 28;
   localparam int PART_MSB = 27;
   localparam int PART_LSB = 12;
   localparam int MAKER_MSB = 11;
   localparam int MAKER_LSB = 1;
   // Arbitrary neutral identity values.
   localparam logic [3:0] ID_REVISION = 4'h1;
   localparam logic [15:0] ID_PART = 16'h5a5a;
   localparam logic [10:0] ID_MAKER = 11'h055;
   localparam logic ID_MARKER = 1'b1;

   // ********************************************
   // Pin synchroniser vector
   // ********************************************
   localparam int PIN_COUNT = 5;
   localparam int PIN_TCK = 4;
   localparam int PIN_TMS = 3;
   localparam int PIN_TDI = 2;
   localparam int PIN_TRST = 1;
   localparam int PIN_DRIVEN = 0;

   // ********************************************
   // Instruction register
   // ********************************************
   localparam int IR_WIDTH = 4;
   localparam logic [3:0] IR_IDCODE = 4'h2;
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
   } tap_state_t;
endpackage
`default_nettype wire

// file: verilog/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the destination clock runs well faster than the pin changes.
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   // ********************************************
   // Synchroniser chain
   // ********************************************
   // The first stage feeds only the second stage, so metastability never reaches logic.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: verilog/test_port.sv
// Test access port of the device: TAP controller, instruction register and identity word.
// Assumes an external controller drives the test clock, mode, data and reset pins,
// and that CORE_CLK is several times faster than the test clock.
// Pin edges are found by oversampling, so the port lags each test clock edge by two or three core cycles.
`default_nettype none
// Functional notes
// - Undriven test reset reads as asserted.
// - Identity register is 32 bits, read-only.
// - Revision, part and maker fields fixed.
// - Sample data and mode on rising test clock.
// - Update data output after falling test clock.
module test_port (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   input wire logic TRST_N,
   input wire logic TRST_N_DRIVEN,
   output logic TDO,
   output logic TDO_OE,
   output logic [test_port_pkg::ID_WIDTH-1:0] DEVICE_IDENTITY_WORD,
   output logic [test_port_pkg::IR_WIDTH-1:0] INSTRUCTION,
   output logic TEST_LOGIC_RESET
);
   import test_port_pkg::*;

   logic [PIN_COUNT-1:0] pins_raw;
   logic [PIN_COUNT-1:0] pins_s;
   logic tck_s, tms_s, tdi_s, trst_n_s, trst_driven_s;
   logic in_cap_dr, in_shift_dr, in_shift_ir, id_selected;
   logic tck_prev_q;
   logic tck_rise, tck_fall;
   logic trst_n_eff;
   logic test_reset;
   tap_state_t state_q, state_d;
   logic [IR_WIDTH-1:0] ir_q, ir_shift_q;
   logic [ID_WIDTH-1:0] dr_shift_q;
   logic bypass_q;
   logic tdo_q, tdo_oe_q;
   logic [ID_WIDTH-1:0] id_word;

   // ********************************************
   // Pin sampling
   // ********************************************
   // All pins go into one vector so that the whole group passes the same two stages.
   assign pins_raw[PIN_TCK] = TCK;
   assign pins_raw[PIN_TMS] = TMS;
   assign pins_raw[PIN_TDI] = TDI;
   assign pins_raw[PIN_TRST] = TRST_N;
   assign pins_raw[PIN_DRIVEN] = TRST_N_DRIVEN;

   // The two reset inputs are combined only after the flops, so no gate ever sees a raw pin.
   pin_sync #(.WIDTH(PIN_COUNT), .INIT('0)) u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .d(pins_raw),
      .q(pins_s)
   );
   assign tck_s = pins_s[PIN_TCK];
   assign tms_s = pins_s[PIN_TMS];
   assign tdi_s = pins_s[PIN_TDI];
   assign trst_n_s = pins_s[PIN_TRST];
   assign trst_driven_s = pins_s[PIN_DRIVEN];
   // An undriven reset pin is taken as low, as the internal pull-down would make it.
   assign trst_n_eff = trst_n_s & trst_driven_s;
   // The flops clear to low, so test reset is asserted from RST until a driven high arrives.
   assign test_reset = ~trst_n_eff;

   // Edge finder on the synchronised test clock.
   // The previous sample clears low to match the idle test clock, so reset release makes no false rise.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         tck_prev_q <= 1'b0;
      end else begin
         tck_prev_q <= tck_s;
      end
   end
   assign tck_rise = tck_s & ~tck_prev_q;
   assign tck_fall = ~tck_s & tck_prev_q;

   // ********************************************
   // State decode
   // ********************************************
   // Named state flags keep the register processes short and give one place to audit the shift paths.
   assign in_cap_dr = (state_q == CAP_DR);
   assign in_shift_dr = (state_q == SHIFT_DR);
   assign in_shift_ir = (state_q == SHIFT_IR);
   // Every code but the identity one acts as bypass, so an unknown instruction never shows stale data.
   assign id_selected = (ir_q == IR_IDCODE);

   // ********************************************
   // Identity word
   // ********************************************
   // Built from constants only, so nothing can write it.
   assign id_word[REV_MSB:REV_LSB] = ID_REVISION;
   assign id_word[PART_MSB:PART_LSB] = ID_PART;
   assign id_word[MAKER_MSB:MAKER_LSB] = ID_MAKER;
   assign id_word[0] = ID_MARKER;
   assign DEVICE_IDENTITY_WORD = id_word;

   // ********************************************
   // TAP state machine
   // ********************************************
   // Next state on the mode input, as the standard controller graph defines.
   always_comb begin
      state_d = state_q;
      case (state_q)
         TLR: state_d = tms_s ? TLR : RTI;
         RTI: state_d = tms_s ? SEL_DR : RTI;
         SEL_DR: state_d = tms_s ? SEL_IR : CAP_DR;
         CAP_DR: state_d = tms_s ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR: state_d = tms_s ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR: state_d = tms_s ? UPD_DR : PAUSE_DR;
         PAUSE_DR: state_d = tms_s ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR: state_d = tms_s ? UPD_DR : SHIFT_DR;
         UPD_DR: state_d = tms_s ? SEL_DR : RTI;
         SEL_IR: state_d = tms_s ? TLR : CAP_IR;
         CAP_IR: state_d = tms_s ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR: state_d = tms_s ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR: state_d = tms_s ? UPD_IR : PAUSE_IR;
         PAUSE_IR: state_d = tms_s ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR: state_d = tms_s ? UPD_IR : SHIFT_IR;
         UPD_IR: state_d = tms_s ? SEL_DR : RTI;
         default: state_d = TLR;
      endcase
   end

   // State advances only on a rising test clock edge; test reset forces logic reset.
   // Test reset wins over a clock edge seen in the same core cycle, so a reset is never missed.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         state_q <= TLR;
      end else if (test_reset) begin
         state_q <= TLR;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // ********************************************
   // Instruction register
   // ********************************************
   // Logic reset selects the identity instruction so the word is readable at once.
   // The captured pattern has its low bit set, which lets a controller find the register length.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ir_q <= IR_IDCODE;
         ir_shift_q <= IR_CAPTURE;
      end else if (test_reset) begin
         ir_q <= IR_IDCODE;
         ir_shift_q <= IR_CAPTURE;
      end else if (tck_rise) begin
         case (state_q)
            TLR: ir_q <= IR_IDCODE;
            CAP_IR: ir_shift_q <= IR_CAPTURE;
            SHIFT_IR: ir_shift_q <= {tdi_s, ir_shift_q[IR_WIDTH-1:1]};
            UPD_IR: ir_q <= ir_shift_q;
            default: ir_q <= ir_q;
         endcase
      end
   end

   // ********************************************
   // Data registers
   // ********************************************
   // Identity shifts towards bit 0, so the least significant bit leaves first.
   // Capture loads the word whatever the instruction; the output stage picks bypass when asked.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         dr_shift_q <= '0;
         bypass_q <= 1'b0;
      end else if (tck_rise) begin
         if (in_cap_dr) begin
            dr_shift_q <= id_word;
            bypass_q <= 1'b0;
         end else if (in_shift_dr) begin
            dr_shift_q <= {tdi_s, dr_shift_q[ID_WIDTH-1:1]};
            bypass_q <= tdi_s;
         end
      end
   end

   // ********************************************
   // Data output
   // ********************************************
   // Output moves only on a falling edge or a test reset, giving the controller a full half period to sample.
   // Enable and data move together, so the pin is never driven with data from another register.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (test_reset) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_q <= in_shift_dr || in_shift_ir;
         if (in_shift_ir) begin
            tdo_q <= ir_shift_q[0];
         end else if (id_selected) begin
            tdo_q <= dr_shift_q[0];
         end else begin
            tdo_q <= bypass_q;
         end
      end
   end

   // ********************************************
   // Port outputs
   // ********************************************
   // Serial outputs come straight from flip-flops, so no decode glitch reaches the pins.
   assign TDO = tdo_q;
   assign TDO_OE = tdo_oe_q;
   assign INSTRUCTION = ir_q;
   assign TEST_LOGIC_RESET = (state_q == TLR);
endmodule
`default_nettype wire

// file: test/test_port_props.sv
// Checker for test_port: identity word and test pin edge timing.
// Assumes CORE_CLK runs eight times faster than TCK.
`default_nettype none
module test_port_props (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   input wire logic TRST_N,
   input wire logic TRST_N_DRIVEN,
   input wire logic TDO,
   input wire logic TDO_OE,
   input wire logic [test_port_pkg::ID_WIDTH-1:0] DEVICE_IDENTITY_WORD,
   input wire logic [test_port_pkg::IR_WIDTH-1:0] INSTRUCTION,
   input wire logic TEST_LOGIC_RESET
);
   import test_port_pkg::*;
   // ***
   // Properties
   // ***
   // Pins pass two sync stages, so pin edges show up two or three core cycles late.
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   open_pin_reset_a: assert property (!TRST_N_DRIVEN [*4] |=> TEST_LOGIC_RESET && !TDO_OE)
      else $error("open reset pin ignored");
   id_frozen_a: assert property (##1 $stable(DEVICE_IDENTITY_WORD))
      else $error("identity word moved");
   id_fields_a: assert property (DEVICE_IDENTITY_WORD[31:1] == {ID_REVISION, ID_PART, ID_MAKER})
      else $error("identity fields wrong");
   id_marker_a: assert property (DEVICE_IDENTITY_WORD[0] == 1'b1)
      else $error("identity bit zero low");
   rise_sample_a: assert property ($changed(TEST_LOGIC_RESET) && TRST_N |-> $past(TCK, 2))
      else $error("state moved off a clock rise");
   fall_drive_a: assert property ($changed({TDO, TDO_OE}) && TRST_N |-> !$past(TCK) && !$past(TCK, 2))
      else $error("output moved off a clock fall");
   first_bit_a: assert property ($rose(TDO_OE) && INSTRUCTION == IR_IDCODE |-> TDO)
      else $error("first shifted bit wrong");
endmodule
bind test_port test_port_props i_props (.CORE_CLK(CORE_CLK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI),
   .TRST_N(TRST_N), .TRST_N_DRIVEN(TRST_N_DRIVEN), .TDO(TDO), .TDO_OE(TDO_OE),
   .DEVICE_IDENTITY_WORD(DEVICE_IDENTITY_WORD), .INSTRUCTION(INSTRUCTION), .TEST_LOGIC_RESET(TEST_LOGIC_RESET));
`default_nettype wire

// file: test/test_ctrl_model.sv
// External test controller: owns the test clock, mode, data and reset pins.
// Assumes the bench calls one task at a time.
`default_nettype none
module test_ctrl_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   output logic trst_n_driven,
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 1ps;
   // Power-up with reset held low until a debug session is wanted.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b0;
      trst_n_driven = 1'b1;
   end
   // One 200 ns period; TDO is read before the fall, while it still stands.
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #100 tck = 1'b1;
      #100 o = tdo;
      tck = 1'b0;
   endtask
   // An open pin falls to its pull-down level.
   task automatic set_reset(input logic drive, input logic level);
      trst_n_driven = drive;
      trst_n = drive & level;
   endtask
endmodule
`default_nettype wire

// file: test/test_port_identity_bench.sv
// Self-checking bench for test_port, driven through the controller model.
// Assumes the controller model and the bound checker are compiled first.
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module test_port_identity_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import test_port_pkg::*;
   localparam logic [31:0] EXP_ID = {ID_REVISION, ID_PART, ID_MAKER, 1'b1};
   logic core_clk, rst, tck, tms, tdi, trst_n, trst_n_driven, tdo, tdo_oe, tlr, o;
   logic [ID_WIDTH-1:0] id_word;
   logic tdo_line;
   logic [IR_WIDTH-1:0] instr;
   logic [IR_WIDTH-1:0] codes [3] = '{IR_BYPASS, 4'h7, IR_IDCODE};
   int err_count = 0;
   int num_checks = 0;
   int seed = 32'h4281;
   // ***
   // Harness
   // ***
   test_port i_dut (.CORE_CLK(core_clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n),
      .TRST_N_DRIVEN(trst_n_driven), .TDO(tdo), .TDO_OE(tdo_oe), .DEVICE_IDENTITY_WORD(id_word),
      .INSTRUCTION(instr), .TEST_LOGIC_RESET(tlr));
   // A released data pin shows the inverse of its last value, so a read outside a shift cannot pass.
   assign tdo_line = tdo_oe ? tdo : ~tdo;
   test_ctrl_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .trst_n_driven(trst_n_driven),
      .tdo(tdo_line));
   // Core clock at 40 MHz.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Queue model of a register of length len preset to cap; the oldest bit leaves first.
   task automatic scan(input bit ir, input int len, input logic [31:0] cap, input int n, input logic [31:0] din);
      bit q[$];
      for (int i = 0; i < len; i++) q.push_back(cap[i]);
      i_ctl.tick(1'b1, 1'b0, o);
      if (ir) i_ctl.tick(1'b1, 1'b0, o);
      repeat (2) i_ctl.tick(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         i_ctl.tick(i == n - 1, din[i], o);
         `CHK({tdo_oe, o}, {1'b1, q.pop_front()})
         q.push_back(din[i]);
      end
      i_ctl.tick(1'b1, 1'b0, o);
      i_ctl.tick(1'b0, 1'b0, o);
   endtask
   // Main sequence; the controller is kept off the core clock edges by a fixed 2 ns.
   initial begin
      rst = 1'b1;
      repeat (12) @(posedge core_clk);
      #2 rst = 1'b0;
      `CHK({tlr, tdo_oe, instr, id_word}, {1'b1, 1'b0, IR_IDCODE, EXP_ID})
      i_ctl.set_reset(1'b1, 1'b1);
      repeat (6) @(posedge core_clk);
      #2 i_ctl.tick(1'b0, 1'b0, o);
      repeat (2) scan(1'b0, 32, EXP_ID, 32, $random(seed));
      foreach (codes[k]) begin
         scan(1'b1, 4, 32'(IR_CAPTURE), 4, 32'(codes[k]));
         `CHK(instr, codes[k])
         if (codes[k] == IR_IDCODE) scan(1'b0, 32, EXP_ID, 32, $random(seed));
         else scan(1'b0, 1, 32'h0000_0000, 8, $random(seed));
      end
      // A core reset with the reset pin driven low, then an open reset pin, must each drop bypass for the identity word.
      for (int k = 0; k < 2; k++) begin
         scan(1'b1, 4, 32'(IR_CAPTURE), 4, 32'(IR_BYPASS));
         @(posedge core_clk);
         #2 rst = (k == 0);
         i_ctl.set_reset(k == 0, 1'b0);
         repeat (6) @(posedge core_clk);
         #2 rst = 1'b0;
         `CHK({tlr, tdo_oe, instr}, {1'b1, 1'b0, IR_IDCODE})
         i_ctl.set_reset(1'b1, 1'b1);
         repeat (6) @(posedge core_clk);
         #2 i_ctl.tick(1'b0, 1'b0, o);
         scan(1'b0, 32, EXP_ID, 32, $random(seed));
      end
      summarize();
   end
   // Cuts a hang short; the sequence needs about 54 us.
   initial begin
      #400000;
      err_count++;
      summarize();
   end
endmodule
`default_nettype wire
